// [rtl/pwm_consts.vh]
// Constants for the centre-aligned six-channel PWM carrier.
// Included by the PWM module; definitions only.
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH
`define CNT_W            12
`define CARRIER_MAX_RST  12'hC35
`define TRIG_DOWN_RST    12'h1E0
`define TRIG_UP_RST      12'hA55
`define DUTY_RST         12'h000
`define SYNC_STAGES      3
`define CLK_MHZ          40
`define CNT_ZERO         12'h000
`define CNT_STEP         12'h001
`define CNT_RST          12'h000
`define SYNC_SH_RST      3'h0
`define PULSE_RST        1'b0
`define GATE_RST         6'h00
`define UP_RST           1'b1
`endif

// [rtl/center_pwm.v]
// Centre-aligned six-channel PWM with carrier latch, start pulse and sync.
// Assumes config ports come from same-clock logic; sync_in is asynchronous.
// How it works
// - Counter runs 0 up to maximum, back down to 0, forever.
// - Maximum 3,125 at 40 MHz gives 6.4 kHz; default value set so.
// - Carrier latch high one cycle at counter zero and at maximum.
// - Start pulse twice per period, fixed distance before each reversal.
// - Start fires on up trigger while rising, down trigger while falling.
// - Master sync out is one cycle wide; next sync in needs two high samples, so ignores it; all programmed alike.
// - Encoder strobe exactly at reversal, no offset.
`timescale 1ns/1ps
`include "pwm_consts.vh"
module center_pwm (
   input  wire        ref_clk,          // System clock
   input  wire        rst_b,            // Synchronous reset, active low
   input  wire [11:0] carrier_max,      // Carrier peak count
   input  wire [11:0] trigger_up,       // Start match while rising
   input  wire [11:0] trigger_down,     // Start match while falling
   input  wire [11:0] duty_a,           // Phase A compare value
   input  wire [11:0] duty_b,           // Phase B compare value
   input  wire [11:0] duty_c,           // Phase C compare value
   input  wire        is_master,        // High: free run, ignore sync_in
   input  wire        sync_in,          // Sync from upstream instance
   output reg         sync_out,         // Sync to downstream instance
   output reg         carrier_latch,    // Encoder strobe pulse
   output reg         start,            // ADC start pulse
   output reg  [5:0]  pwm_out,          // {c_lo,c_hi,b_lo,b_hi,a_lo,a_hi}
   output reg  [11:0] count_out,        // Current carrier count
   output reg         counting_up       // Direction of carrier
);
   // One-hot carrier direction
   localparam [1:0] DIR_UP   = 2'b01;
   localparam [1:0] DIR_DOWN = 2'b10;

   reg  [11:0]             cnt_reg;
   reg  [11:0]             cnt_next;
   reg  [1:0]              dir_reg;
   reg  [1:0]              dir_next;
   reg  [11:0]             duty_a_reg;
   reg  [11:0]             duty_b_reg;
   reg  [11:0]             duty_c_reg;
   reg  [`SYNC_STAGES-1:0] sync_sh_reg;
   reg                     sync_st_reg;
   wire                    rising;
   wire                    at_zero;
   wire                    at_max;
   wire                    reload;
   wire                    start_hit;
   wire                    sync_agree;
   wire                    sync_edge;
   wire [2:0]              gate_hi;

   // High-side gate on while the carrier sits below the duty value
   function gate_on;
      input [11:0] duty;
      input [11:0] cnt;
      begin
         gate_on = (cnt < duty);
      end
   endfunction

   // Start compare, shared by both carrier directions
   function trig_hit;
      input [11:0] cnt;
      input [11:0] trig;
      begin
         trig_hit = (cnt == trig);
      end
   endfunction

   assign rising     = (dir_reg == DIR_UP);
   assign at_zero    = (cnt_reg == `CNT_ZERO);
   // Peak caught at or above maximum: a lowered maximum cannot run away
   assign at_max     = rising & (cnt_reg >= carrier_max);
   assign reload     = at_zero | at_max;
   assign start_hit  = (rising & trig_hit(cnt_reg, trigger_up)) |
                       (~rising & trig_hit(cnt_reg, trigger_down));
   // Second and third stages agree: stable level seen
   assign sync_agree = (sync_sh_reg[`SYNC_STAGES-1] ==
                        sync_sh_reg[`SYNC_STAGES-2]);
   // Slave lags a sync_in rise held two cycles by the synchroniser, a fixed offset
   assign sync_edge  = ~is_master & sync_agree &
                       sync_sh_reg[`SYNC_STAGES-1] & ~sync_st_reg;
   assign gate_hi[0] = gate_on(duty_a_reg, cnt_reg);
   assign gate_hi[1] = gate_on(duty_b_reg, cnt_reg);
   assign gate_hi[2] = gate_on(duty_c_reg, cnt_reg);

   // Next count: up to the peak, down to zero, or restart on sync
   always @* begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      if (sync_edge) begin
         cnt_next = `CNT_ZERO;
         dir_next = DIR_UP;
      end else begin
         case (dir_reg)
            DIR_UP: begin
               if (at_max) begin
                  dir_next = DIR_DOWN;
                  cnt_next = cnt_reg - `CNT_STEP;
               end else begin
                  cnt_next = cnt_reg + `CNT_STEP;
               end
            end
            DIR_DOWN: begin
               if (at_zero) begin
                  dir_next = DIR_UP;
                  cnt_next = `CNT_STEP;
               end else begin
                  cnt_next = cnt_reg - `CNT_STEP;
               end
            end
            default: begin
               // Broken direction code: restart the carrier cleanly
               dir_next = DIR_UP;
               cnt_next = `CNT_ZERO;
            end
         endcase
      end
   end

   // Three-stage synchroniser for the upstream sync pin
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sync_sh_reg <= `SYNC_SH_RST;
         sync_st_reg <= `PULSE_RST;
      end else begin
         sync_sh_reg <= {sync_sh_reg[`SYNC_STAGES-2:0], sync_in};
         if (sync_agree) begin
            sync_st_reg <= sync_sh_reg[`SYNC_STAGES-1];
         end
      end
   end

   // Carrier counter and its direction
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_reg <= `CNT_RST;
         dir_reg <= DIR_UP;
      end else begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
      end
   end

   // Reload only at reversal so a half period is never torn
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         duty_a_reg <= `DUTY_RST;
         duty_b_reg <= `DUTY_RST;
         duty_c_reg <= `DUTY_RST;
      end else if (reload) begin
         duty_a_reg <= duty_a;
         duty_b_reg <= duty_b;
         duty_c_reg <= duty_c;
      end
   end

   // Encoder strobe at both reversal points, aligned with count_out
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         carrier_latch <= `PULSE_RST;
      end else begin
         carrier_latch <= at_zero | at_max;
      end
   end

   // Zero marks the period start in one cycle, too short for the next instance's sync_in filter
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sync_out <= `PULSE_RST;
      end else begin
         sync_out <= at_zero;
      end
   end

   // ADC start, ahead of each reversal by the trigger distance
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         start <= `PULSE_RST;
      end else begin
         start <= start_hit;
      end
   end

   // Pairs are exact complements with no dead time;
   // the power stage must add its own if it needs one
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         pwm_out <= `GATE_RST;
      end else begin
         pwm_out[0] <= gate_hi[0];
         pwm_out[1] <= ~gate_hi[0];
         pwm_out[2] <= gate_hi[1];
         pwm_out[3] <= ~gate_hi[1];
         pwm_out[4] <= gate_hi[2];
         pwm_out[5] <= ~gate_hi[2];
      end
   end

   // Carrier position as seen outside, one cycle late like the pulses
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         count_out <= `CNT_RST;
      end else begin
         count_out <= cnt_reg;
      end
   end

   // Direction flag, same delay as count_out
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         counting_up <= `UP_RST;
      end else begin
         counting_up <= rising;
      end
   end
endmodule // center_pwm

// [dv/pwm_monitor.sv]
// Port checks for center_pwm.
// Assumes fixed config during run.
`timescale 1ns/1ps
module pwm_monitor (
   input wire        ref_clk,       // clk
   input wire        rst_b,         // rst
   input wire [11:0] carrier_max,   // peak
   input wire [11:0] trigger_up,    // up match
   input wire [11:0] trigger_down,  // down match
   input wire        is_master,     // master
   input wire        sync_in,       // sync in
   input wire        sync_out,      // sync out
   input wire        carrier_latch, // latch
   input wire        start,         // start
   input wire [5:0]  pwm_out,       // gates
   input wire [11:0] count_out,     // count
   input wire        counting_up);  // dir
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   count_up_a: assert property ($past(rst_b) && is_master && counting_up
      && count_out < carrier_max
      |=> count_out == $past(count_out) + 12'h001) else $error("bad step");
   turn_top_a: assert property (is_master && count_out == carrier_max
      |=> count_out == carrier_max - 12'h001) else $error("bad turn");
   latch_pos_a: assert property ($past(rst_b) |-> carrier_latch ==
      (count_out == 12'h000 || count_out == carrier_max)) else $error("latch");
   latch_once_a: assert property (carrier_latch |=> !carrier_latch)
      else $error("latch long");
   start_pos_a: assert property ($past(rst_b) |-> start == (counting_up ?
      count_out == trigger_up : count_out == trigger_down)) else $error("start");
   sync_pos_a: assert property ($past(rst_b) |-> sync_out ==
      (count_out == 12'h000)) else $error("sync out");
   pwm_pair_a: assert property ($past(rst_b) |-> ((((pwm_out >> 1) ^ pwm_out)
      & 6'h15) == 6'h15)) else $error("pair");
   gate_dir_a: assert property (is_master && $changed(pwm_out[0])
      |-> pwm_out[0] != counting_up) else $error("gate edge wrong way");
   resync_a: assert property (!is_master && $rose(sync_in)
      |-> ##[2:10] count_out == 12'h000) else $error("resync");
   cover property (start && counting_up);
   cover property (start && !counting_up);
   cover property (!is_master && $rose(sync_in));
endmodule // pwm_monitor
bind center_pwm pwm_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b),
   .carrier_max(carrier_max), .trigger_up(trigger_up), .sync_in(sync_in),
   .trigger_down(trigger_down), .is_master(is_master), .start(start),
   .sync_out(sync_out), .carrier_latch(carrier_latch), .pwm_out(pwm_out),
   .count_out(count_out), .counting_up(counting_up));

// [dv/host_side.sv]
// ADC and software model: irq after start, then new duty.
// Assumes start pulses at least ten cycles apart.
`timescale 1ns/1ps
module host_side (
   input  wire        ref_clk, // clk
   input  wire        start,   // ADC start
   input  wire [11:0] svm_val, // next duty
   output reg  [11:0] duty);   // duty out
   reg [3:0] conv_reg;
   initial begin duty = 12'h000; conv_reg = 4'h0; end
   always @(posedge ref_clk) begin
      if (start) conv_reg <= 4'h9;
      else if (conv_reg != 4'h0) conv_reg <= conv_reg - 4'h1;
      if (conv_reg == 4'h1) duty <= svm_val;
   end
endmodule // host_side

// [dv/test_center_aligned_pwm_with_sync.sv]
// Bench: one period measured, then sync as slave and master.
// Assumes the far-side model feeds all three duty inputs alike.
`timescale 1ns/1ps
module test_center_aligned_pwm_with_sync;
   reg         ref_clk, rst_b, is_master, sync_in;
   reg  [11:0] svm_val;
   wire [11:0] duty, count_out;
   wire [5:0]  pwm_out;
   wire        sync_out, carrier_latch, start, counting_up;
   integer     num_errors, n_checks, i, k, n_l, n_s, n_y, n_h;
   center_pwm uut (.ref_clk(ref_clk), .rst_b(rst_b), .carrier_max(12'hC35),
      .trigger_up(12'hA55), .trigger_down(12'h1E0), .duty_a(duty),
      .duty_b(duty), .duty_c(duty), .is_master(is_master), .start(start),
      .sync_in(sync_in), .sync_out(sync_out), .carrier_latch(carrier_latch),
      .pwm_out(pwm_out), .count_out(count_out), .counting_up(counting_up));
   host_side far (.ref_clk(ref_clk), .start(start), .svm_val(svm_val),
      .duty(duty));
   task check(input [31:0] seen, input [31:0] exp, input [47:0] what);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %0d seen %0d", what, exp, seen);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task wait_zero;
      for (i = 0; !(carrier_latch === 1'b1 && count_out === 12'h000); i++) begin
         @(posedge ref_clk) #1;
         if (i > 7000) begin
            num_errors = num_errors + 1;
            complete_run;
         end
      end
   endtask
   initial begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      {num_errors, n_checks, n_l, n_s, n_y, n_h} = 0;
      {rst_b, sync_in, is_master, svm_val} = {3'b001, 12'h100};
      repeat (10) @(posedge ref_clk);
      #1 rst_b = 1;
      wait_zero;
      @(posedge ref_clk) #1;
      wait_zero;
      repeat (6250) begin
         @(posedge ref_clk) #1;
         {n_l, n_s, n_y} = {n_l + carrier_latch, n_s + start, n_y + sync_out};
         n_h = n_h + pwm_out[0] + pwm_out[2] + pwm_out[4];
      end
      check(count_out, 0, "period");
      check(n_l, 2, "latch");
      check(n_s, 2, "start");
      check(n_y, 1, "sync");
      check(n_h, 1533, "duty");
      for (k = 0; k < 2; k++) begin
         is_master = k[0];
         repeat (300) @(posedge ref_clk);
         #1 sync_in = 1;
         n_h = 0;
         repeat (12) begin
            @(posedge ref_clk) #1;
            if (count_out === 12'h000) n_h = 1;
         end
         sync_in = 0;
         check(n_h, 1 - k, "resync");
      end
      complete_run;
   end
endmodule // test_center_aligned_pwm_with_sync
